//--- ppi_busy_timer.sv
// Busy timer: holds ready low for a fixed count after an operation starts.
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_busy_timer (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy
);
  import ppi_pkg::*;
  localparam int unsigned CNT_MAX = `BUSY_CYCLES;
  op_e         state_ff;   // Current timer state.
  op_e         nxt_state;  // Next timer state.
  logic [15:0] cnt_ff;     // Remaining busy cycles.
  logic [15:0] nxt_cnt;    // Next remaining count.

  // Load the count on start and run it down to zero.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      OP_IDLE: begin
        if (start) begin
          nxt_state = OP_BUSY;
          nxt_cnt   = CNT_MAX[15:0];
        end
      end
      OP_BUSY: begin
        if (cnt_ff <= 16'h0001) begin
          nxt_state = OP_IDLE;
          nxt_cnt   = 16'h0000;
        end else begin
          nxt_cnt = cnt_ff - 16'h0001;
        end
      end
      default: nxt_state = OP_IDLE;
    endcase
  end

  // Register the timer state.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= OP_IDLE;
      cnt_ff   <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  assign busy = (state_ff == OP_BUSY);
endmodule : ppi_busy_timer

//--- ppi_core.sv
// Parallel programming port: command, address and data latches, fuses and page buffers.
`timescale 1ns/1ps
`include "ppi_map.svh"
module ppi_core (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              reset_pin_n,
  input  wire logic              high_voltage,
  input  wire logic              serial_mode,
  input  wire ppi_pkg::ctrl_pins_s pins,
  input  wire logic [7:0]        data_in,
  output logic [7:0]             data_out,
  output logic                   data_oe,
  output logic                   ready_busy_out,
  output logic                   prog_mode,
  output ppi_pkg::fuse_pair_s    active_fuses,
  output logic                   eeprom_keep_live,
  output logic [7:0]             rc_calibration_register
);
  import ppi_pkg::*;

  // Calibration values; the high byte of signature rows 0..3.
  localparam logic [7:0] CAL1 = `CAL_DEFAULT;
  localparam logic [7:0] CAL2 = `CAL_DEFAULT;
  localparam logic [7:0] CAL4 = `CAL_DEFAULT;
  localparam logic [7:0] CAL8 = `CAL_DEFAULT;

  mode_e       mode_ff, nxt_mode;            // Programming mode state.
  logic [3:0]  tog_ff, nxt_tog;              // Load pulses seen under reset.
  logic        xl_ff, wr_ff, pg_ff;          // Previous pin levels for edges.
  logic [7:0]  cmd_ff, nxt_cmd;              // Last loaded command.
  logic [15:0] addr_ff, nxt_addr;            // Loaded address.
  logic [15:0] dat_ff, nxt_dat;              // Loaded data word.
  fuse_pair_s  fuse_ff, nxt_fuse;            // Stored fuse bytes.
  fuse_pair_s  act_ff, nxt_act;              // Captured working copy.
  logic [7:0]  lock_ff, nxt_lock;            // Lock bits.
  logic [7:0]  cal_ff;                       // Oscillator calibration copy.
  logic [15:0] fbuf [`FLASH_PAGE_WORDS];     // Flash page buffer.
  logic [7:0]  ebuf [`EEPROM_PAGE_BYTES];    // Eeprom page buffer.
  logic        start_op;                     // Write strobe starts an operation.
  logic        busy;                         // Operation in progress.

  wire xl_rise = pins.load_pulse_in & ~xl_ff;      // Load pulse rising edge.
  wire wr_fall = ~pins.wr_n & wr_ff;               // Write strobe falling edge.
  wire pg_rise = pins.page_latch_strobe & ~pg_ff;  // Page strobe rising edge.
  wire in_prog = (mode_ff == ST_PROG);

  // Returns one when the command starts a write-type operation.
  function automatic logic is_write(input logic [7:0] c);
    is_write = (c == `CMD_CHIP_ERASE) || (c == `CMD_WRITE_FUSE) ||
               (c == `CMD_WRITE_LOCK) || (c == `CMD_WRITE_FLASH) ||
               (c == `CMD_WRITE_EEPROM);
  endfunction : is_write

  // Entry: count load pulses under reset, then require quiet pins at the high-voltage edge.
  always_comb begin
    nxt_mode = mode_ff;
    nxt_tog  = tog_ff;
    case (mode_ff)
      ST_OFF: begin
        if (!reset_pin_n && !high_voltage) begin
          if (xl_rise && tog_ff != 4'hF) nxt_tog = tog_ff + 4'h1;
          if (tog_ff >= `ENTRY_TOGGLES) nxt_mode = ST_ARMED;
        end else begin
          nxt_tog = 4'h0;
        end
      end
      ST_ARMED: begin
        if (high_voltage) begin
          // A high page strobe, action pin or first byte select at the high-voltage edge aborts entry.
          if ({pins.page_latch_strobe, pins.pin_action, pins.byte_select_one} == 4'h0)
            nxt_mode = ST_PROG;
          else
            nxt_mode = ST_OFF;
        end
      end
      ST_PROG: begin
        // Clearing the count here means a later entry needs six fresh toggles.
        nxt_tog = 4'h0;
        if (!high_voltage) nxt_mode = ST_OFF;
      end
      default: nxt_mode = ST_OFF;
    endcase
  end

  // Latch command, address and data on load pulses; commit writes on the write strobe.
  always_comb begin
    nxt_cmd  = cmd_ff;
    nxt_addr = addr_ff;
    nxt_dat  = dat_ff;
    nxt_fuse = fuse_ff;
    nxt_lock = lock_ff;
    nxt_act  = act_ff;
    start_op = 1'b0;
    if (in_prog && xl_rise && !busy) begin
      case (pins.pin_action)
        `ACT_ADDR: begin
          if (pins.byte_select_one) nxt_addr[15:8] = data_in;
          else nxt_addr[7:0] = data_in;
        end
        `ACT_DATA: begin
          if (pins.byte_select_one) nxt_dat[15:8] = data_in;
          else nxt_dat[7:0] = data_in;
        end
        `ACT_CMD: nxt_cmd = data_in;
        default: ;
      endcase
    end
    if (in_prog && wr_fall && !busy && is_write(cmd_ff)) begin
      start_op = 1'b1;
      case (cmd_ff)
        `CMD_WRITE_FUSE: begin
          if (lock_ff[`LOCK_LB1] && !pins.byte_select_two) begin
            if (pins.byte_select_one) begin
              nxt_fuse.high = dat_ff[7:0];
              if (serial_mode)
                nxt_fuse.high[`FH_SERIAL_PROG] = fuse_ff.high[`FH_SERIAL_PROG];
            end else begin
              nxt_fuse.low = dat_ff[7:0];
            end
          end
        end
        `CMD_WRITE_LOCK: nxt_lock = lock_ff & dat_ff[7:0];  // Only programs.
        `CMD_CHIP_ERASE: nxt_lock = `LOCK_DEFAULT;
        default: ;
      endcase
    end
    // Outside programming mode the working copy tracks the stored bytes.
    if (!in_prog && mode_ff != ST_ARMED) nxt_act = fuse_ff;
    if (mode_ff == ST_ARMED && nxt_mode == ST_PROG) nxt_act = fuse_ff;
    // The keep-eeprom bit follows the stored fuse at once.
    nxt_act.high[`FH_KEEP_EEPROM] = nxt_fuse.high[`FH_KEEP_EEPROM];
  end

  // Read path: data returned on the bus while output enable is low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_out <= 8'h00;
    end else begin
      case (cmd_ff)
        `CMD_READ_SIG: begin
          if (pins.byte_select_one) begin
            case (addr_ff[1:0])
              2'h0: data_out <= CAL1;
              2'h1: data_out <= CAL2;
              2'h2: data_out <= CAL4;
              default: data_out <= CAL8;
            endcase
          end else begin
            case (addr_ff[1:0])
              2'h0: data_out <= `SIG_BYTE0;
              2'h1: data_out <= `SIG_BYTE1;
              2'h2: data_out <= `SIG_BYTE2;
              default: data_out <= 8'hFF;
            endcase
          end
        end
        `CMD_READ_FUSE: begin
          if (pins.byte_select_two) data_out <= lock_ff;
          // The serial path never sees the serial enable fuse: it reads as unprogrammed.
          else if (pins.byte_select_one && serial_mode)
            data_out <= fuse_ff.high | (8'h01 << `FH_SERIAL_PROG);
          else if (pins.byte_select_one) data_out <= fuse_ff.high;
          else data_out <= fuse_ff.low;
        end
        `CMD_READ_FLASH: begin
          if (pins.byte_select_one)
            data_out <= fbuf[addr_ff[`FLASH_WORD_BITS-1:0]][15:8];
          else
            data_out <= fbuf[addr_ff[`FLASH_WORD_BITS-1:0]][7:0];
        end
        `CMD_READ_EEPROM: data_out <= ebuf[addr_ff[`EEPROM_BYTE_BITS-1:0]];
        default: data_out <= 8'h00;
      endcase
    end
  end

  // Page buffers take the loaded data on the page strobe; the word index is the low address.
  always_ff @(posedge sys_clk) begin
    if (in_prog && pg_rise) begin
      if (cmd_ff == `CMD_WRITE_FLASH)
        fbuf[addr_ff[`FLASH_WORD_BITS-1:0]] <= dat_ff;
      else if (cmd_ff == `CMD_WRITE_EEPROM)
        ebuf[addr_ff[`EEPROM_BYTE_BITS-1:0]] <= dat_ff[7:0];
    end
  end

  // State registers; fuses restart at their factory values.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_ff <= ST_OFF;
      tog_ff  <= 4'h0;
      xl_ff   <= 1'b0;
      wr_ff   <= 1'b1;
      pg_ff   <= 1'b0;
      cmd_ff  <= `CMD_NOP;
      addr_ff <= 16'h0000;
      dat_ff  <= 16'h0000;
      fuse_ff <= {`FUSE_HIGH_DEFAULT, `FUSE_LOW_DEFAULT};
      act_ff  <= {`FUSE_HIGH_DEFAULT, `FUSE_LOW_DEFAULT};
      lock_ff <= `LOCK_DEFAULT;
      cal_ff  <= `CAL_DEFAULT;
    end else begin
      mode_ff <= nxt_mode;
      tog_ff  <= nxt_tog;
      xl_ff   <= pins.load_pulse_in;
      wr_ff   <= pins.wr_n;
      pg_ff   <= pins.page_latch_strobe;
      cmd_ff  <= nxt_cmd;
      addr_ff <= nxt_addr;
      dat_ff  <= nxt_dat;
      fuse_ff <= nxt_fuse;
      act_ff  <= nxt_act;
      lock_ff <= nxt_lock;
      cal_ff  <= CAL1;
    end
  end

  ppi_busy_timer u_busy (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (start_op),
    .busy    (busy)
  );

  assign data_oe                 = in_prog & ~pins.oe_n;
  assign ready_busy_out          = ~busy;
  assign prog_mode               = in_prog;
  assign active_fuses            = act_ff;
  assign eeprom_keep_live        = act_ff.high[`FH_KEEP_EEPROM];
  assign rc_calibration_register = cal_ff;

  // Checks. Each one guards a rule that the pins alone show only late or not at all.
  // A write strobe must take ready low on the very next cycle.
  a_busy_after_wr: assert property (@(posedge sys_clk) disable iff (rst)
    start_op |=> !ready_busy_out) else $error("ready not low after write");
  // The bus is driven only while output enable is held low.
  a_oe_drive: assert property (@(posedge sys_clk) disable iff (rst)
    data_oe |-> !pins.oe_n) else $error("bus driven without enable");
  // A released output enable leaves the bus to the programmer.
  a_oe_off: assert property (@(posedge sys_clk) disable iff (rst)
    pins.oe_n |-> !data_oe) else $error("bus driven after release");
  // A programmed first lock bit freezes the stored fuses.
  a_lock_fuse: assert property (@(posedge sys_clk) disable iff (rst)
    !lock_ff[`LOCK_LB1] |=> $stable(fuse_ff)) else $error("fuse changed while locked");
  // Erase clears the locks but never the fuses.
  a_erase_keep: assert property (@(posedge sys_clk) disable iff (rst)
    (start_op && cmd_ff == `CMD_CHIP_ERASE) |=> $stable(fuse_ff)) else $error("erase hit fuse");
  // Lock writes can only program bits; only erase releases them.
  a_lock_one_way: assert property (@(posedge sys_clk) disable iff (rst)
    (start_op && cmd_ff == `CMD_WRITE_LOCK) |=> (lock_ff & ~$past(lock_ff)) == 8'h00)
    else $error("lock bit released by a write");
  // The command stays put unless a load pulse brings a new one.
  a_cmd_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !(in_prog && xl_rise) |=> $stable(cmd_ff)) else $error("command changed");
  // Serial programming may never move the serial enable fuse.
  a_serial_keep: assert property (@(posedge sys_clk) disable iff (rst)
    serial_mode |=> $stable(fuse_ff.high[`FH_SERIAL_PROG])) else $error("serial fuse moved");
  // The keep-eeprom bit is the one fuse that acts at once in programming mode.
  a_keep_live: assert property (@(posedge sys_clk) disable iff (rst)
    in_prog ##1 in_prog |-> act_ff.high[`FH_KEEP_EEPROM] == fuse_ff.high[`FH_KEEP_EEPROM])
    else $error("keep fuse not live");
  // All other working fuse bits hold still until programming mode ends.
  a_fuse_frozen: assert property (@(posedge sys_clk) disable iff (rst)
    (in_prog && nxt_mode == ST_PROG)
    |=> $stable(act_ff.low) && $stable(act_ff.high & `FH_FROZEN_MASK))
    else $error("working fuses moved in programming mode");
  // The pulse count is cleared while in programming mode.
  a_entry_recount: assert property (@(posedge sys_clk) disable iff (rst)
    in_prog |=> tog_ff == 4'h0) else $error("entry count kept in programming mode");
  // The first signature row answers with the first identity byte.
  a_sig_read: assert property (@(posedge sys_clk) disable iff (rst)
    (cmd_ff == `CMD_READ_SIG && !pins.byte_select_one && addr_ff[1:0] == 2'h0)
    |=> data_out == `SIG_BYTE0) else $error("signature byte wrong");
  // Reset leaves the 1 MHz calibration byte in the oscillator register.
  a_cal_load: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 rc_calibration_register == CAL1) else $error("calibration not loaded");
endmodule : ppi_core

//--- ppi_map.svh
// Register layout, command codes, fuse defaults and timing counts of the programming port.
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH
`define CMD_CHIP_ERASE   8'h80
`define CMD_WRITE_FUSE   8'h40
`define CMD_WRITE_LOCK   8'h20
`define CMD_WRITE_FLASH  8'h10
`define CMD_WRITE_EEPROM 8'h11
`define CMD_READ_SIG     8'h08
`define CMD_READ_FUSE    8'h04
`define CMD_READ_FLASH   8'h02
`define CMD_READ_EEPROM  8'h03
`define CMD_NOP          8'h00
`define ACT_ADDR         2'h0
`define ACT_DATA         2'h1
`define ACT_CMD          2'h2
`define FUSE_HIGH_DEFAULT 8'h99
`define FUSE_LOW_DEFAULT  8'hE1
`define LOCK_DEFAULT      8'hFF
`define FH_KEEP_EEPROM    3
`define FH_SERIAL_PROG    5
`define FH_FROZEN_MASK    8'hF7
`define LOCK_LB1          0
`define FLASH_WORD_BITS   7
`define EEPROM_BYTE_BITS  3
`define FLASH_PAGE_WORDS  128
`define EEPROM_PAGE_BYTES 8
`define ENTRY_TOGGLES     4'h6
`define SIG_BYTE0         8'h5A  // Arbitrary identity value.
`define SIG_BYTE1         8'hA5  // Arbitrary identity value.
`define SIG_BYTE2         8'h3C  // Arbitrary identity value.
`define CAL_DEFAULT       8'h80
`define BUSY_NS           1000
`define CLK_NS            8
`define BUSY_CYCLES       ((`BUSY_NS) / (`CLK_NS))
`endif

//--- ppi_pkg.sv
// Types shared by the programming port modules.
package ppi_pkg;
  typedef struct packed {
    logic       load_pulse_in;
    logic [1:0] pin_action;
    logic       byte_select_one;
    logic       byte_select_two;
    logic       page_latch_strobe;
    logic       wr_n;
    logic       oe_n;
  } ctrl_pins_s;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } fuse_pair_s;
  typedef enum logic [1:0] {ST_OFF, ST_ARMED, ST_PROG} mode_e;
  typedef enum logic [1:0] {OP_IDLE, OP_BUSY} op_e;
endpackage : ppi_pkg

//--- prog_model.sv
// Behavioural model of the external parallel programmer that drives the port.
`timescale 1ns/1ps
module prog_model (
  input  wire logic         sys_clk,
  input  wire logic         ready_busy_out,
  input  wire logic [7:0]   data_out,
  input  wire logic         data_oe,
  output ppi_pkg::ctrl_pins_s pins,
  output logic [7:0]        drv,
  output logic              reset_pin_n,
  output logic              high_voltage
);
  import ppi_pkg::*;
  // Hold time of every pin change outside the write strobe: 32 cycles is 256 ns, just over the minimum.
  localparam int HOLD = 32;

  // Idle levels: write and output enable strobes high, load and page strobes low, action pins at no-action, reset pin released.
  initial begin
    pins = '0;
    pins.pin_action = 2'h3;
    pins.wr_n = 1'b1;
    pins.oe_n = 1'b1;
    drv = 8'h00;
    reset_pin_n = 1'b1;
    high_voltage = 1'b0;
  end

  // Waits one pulse width; every pin change except those of the write strobe is followed by one of these.
  task automatic hold;
    repeat (HOLD) @(posedge sys_clk);
  endtask : hold

  // Puts a byte on the bus and gives the load pin one positive pulse.
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] d);
    @(posedge sys_clk);
    pins.pin_action <= act;
    pins.byte_select_one <= bs1;
    drv <= d;
    hold();
    pins.load_pulse_in <= 1'b1;
    hold();
    pins.load_pulse_in <= 1'b0;
    hold();
  endtask : load

  // Entry: reset low, n load pulses, pins to 0000, then the high voltage.
  task automatic enter(input int n);
    @(posedge sys_clk);
    reset_pin_n <= 1'b0;
    high_voltage <= 1'b0;
    repeat (n) load(2'h3, 1'b0, 8'h00);
    pins.page_latch_strobe <= 1'b0;
    pins.pin_action <= 2'h0;
    pins.byte_select_one <= 1'b0;
    pins.byte_select_two <= 1'b0;
    hold();
    high_voltage <= 1'b1;
    hold();
  endtask : enter

  // Gives the page strobe one positive pulse.
  task automatic page;
    @(posedge sys_clk);
    pins.page_latch_strobe <= 1'b1;
    hold();
    pins.page_latch_strobe <= 1'b0;
    hold();
  endtask : page

  // Leaves programming mode by removing the high voltage.
  task automatic leave;
    @(posedge sys_clk);
    high_voltage <= 1'b0;
    hold();
  endtask : leave

  // Write strobe; holds it until ready drops, then counts the busy cycles.
  task automatic strobe(input logic bs1, output int lat, output int busy);
    @(posedge sys_clk);
    pins.byte_select_one <= bs1;
    pins.wr_n <= 1'b0;
    lat = 0;
    do begin
      @(negedge sys_clk);
      lat++;
    end while (ready_busy_out !== 1'b0 && lat < 8);
    @(posedge sys_clk);
    pins.wr_n <= 1'b1;
    busy = 1;
    // No new request until ready returns high; the count is bounded.
    while (ready_busy_out !== 1'b1 && busy < 300) begin
      @(negedge sys_clk);
      if (ready_busy_out !== 1'b1) busy++;
    end
  endtask : strobe

  // Read cycle: result is {oe while reading, oe after release, data}.
  task automatic rd(input logic bs1, input logic bs2, output logic [9:0] r);
    @(posedge sys_clk);
    pins.byte_select_one <= bs1;
    pins.byte_select_two <= bs2;
    pins.oe_n <= 1'b0;
    hold();
    @(negedge sys_clk);
    r[9] = data_oe;
    r[7:0] = data_out;
    @(posedge sys_clk);
    pins.oe_n <= 1'b1;
    pins.byte_select_two <= 1'b0;
    hold();
    @(negedge sys_clk);
    r[8] = data_oe;
  endtask : rd
endmodule : prog_model

//--- tb_parallel_program_fuse_interface.sv
// Self-checking testbench of the parallel programming port.
`timescale 1ns/1ps
`include "ppi_map.svh"
module tb_parallel_program_fuse_interface;
  import ppi_pkg::*;
  logic       sys_clk;     // 125 MHz system clock.
  logic       rst;         // Asynchronous reset, active high.
  logic       serial_mode; // Serial path active.
  ctrl_pins_s pins;
  fuse_pair_s active_fuses;
  logic [7:0] drv, data_in, data_out, cal;
  logic       reset_pin_n, high_voltage, data_oe, ready, prog_mode, keep_live;
  int         errors, check_count, cycles;

  // The bus carries the port's byte while it drives, else the programmer's.
  assign data_in = data_oe ? data_out : drv;

  ppi_core uut (.sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .high_voltage(high_voltage), .serial_mode(serial_mode), .pins(pins),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .ready_busy_out(ready),
    .prog_mode(prog_mode), .active_fuses(active_fuses), .eeprom_keep_live(keep_live),
    .rc_calibration_register(cal));

  prog_model m (.sys_clk(sys_clk), .ready_busy_out(ready), .data_out(data_out),
    .data_oe(data_oe), .pins(pins), .drv(drv), .reset_pin_n(reset_pin_n),
    .high_voltage(high_voltage));

  // Clock; the run needs about 6200 cycles, so 20000 means a hang.
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Loads a command, then a data byte, then strobes and checks the busy time.
  task automatic op(input logic [7:0] c, input logic [7:0] d, input logic bs1);
    int lat, busy;
    m.load(2'h2, 1'b0, c);
    m.load(2'h1, 1'b0, d);
    m.strobe(bs1, lat, busy);
    chk(16'(lat), 16'h0002, "ready drop delay");
    chk(16'(busy), 16'(`BUSY_CYCLES), "busy length");
  endtask : op

  // Reads one fuse or lock byte and compares it.
  task automatic rf(input logic bs1, input logic bs2, input logic [7:0] e);
    logic [9:0] r;
    m.load(2'h2, 1'b0, 8'h04);
    m.rd(bs1, bs2, r);
    chk({8'h00, r[7:0]}, {8'h00, e}, "fuse readback");
  endtask : rf

  // Defaults after reset, before any programming.
  task automatic t_reset;
    chk(active_fuses, 16'h99E1, "default fuses");
    chk({14'h0000, ready, prog_mode}, 16'h0002, "ready, mode");
    chk({15'h0000, keep_live}, 16'h0001, "keep flag");
    chk({8'h00, cal}, 16'h0080, "calibration copy");
  endtask : t_reset

  // Five pulses fall short of entry; six succeed.
  task automatic t_entry;
    m.enter(5);
    chk({15'h0000, prog_mode}, 16'h0000, "short entry");
    m.leave();
    m.enter(6);
    chk({15'h0000, prog_mode}, 16'h0001, "entry");
  endtask : t_entry

  // Signature bytes with one command load, and the 1 MHz calibration byte.
  task automatic t_signature;
    logic [9:0]  r;
    logic [23:0] sig;
    sig = {8'h3C, 8'hA5, 8'h5A};
    m.load(2'h2, 1'b0, 8'h08);
    for (int i = 0; i < 3; i++) begin
      m.load(2'h0, 1'b0, 8'(i));
      m.rd(1'b0, 1'b0, r);
      chk({8'h00, r[7:0]}, {8'h00, sig[8*i +: 8]}, "signature");
      chk({14'h0000, r[9:8]}, 16'h0002, "bus direction");
    end
    m.load(2'h0, 1'b0, 8'h00);
    m.rd(1'b1, 1'b0, r);
    chk({8'h00, r[7:0]}, 16'h0080, "calibration byte");
  endtask : t_signature

  // Page buffers: a flash word and an eeprom byte go in and read back.
  task automatic t_pages;
    logic [9:0] r;
    m.load(2'h2, 1'b0, 8'h10);
    m.load(2'h0, 1'b0, 8'h05);
    m.load(2'h1, 1'b0, 8'h34);
    m.load(2'h1, 1'b1, 8'h12);
    m.page();
    m.load(2'h2, 1'b0, 8'h02);
    m.rd(1'b0, 1'b0, r);
    chk({8'h00, r[7:0]}, 16'h0034, "flash low byte");
    m.rd(1'b1, 1'b0, r);
    chk({8'h00, r[7:0]}, 16'h0012, "flash high byte");
    m.load(2'h2, 1'b0, 8'h11);
    m.load(2'h1, 1'b0, 8'h77);
    m.page();
    m.load(2'h2, 1'b0, 8'h03);
    m.rd(1'b0, 1'b0, r);
    chk({8'h00, r[7:0]}, 16'h0077, "eeprom byte");
  endtask : t_pages

  // Fuse writes: serial guard, erase, lock bit and latching on exit.
  task automatic t_fuses;
    op(8'h40, 8'h11, 1'b1);
    chk({15'h0000, keep_live}, 16'h0000, "keep flag live");
    chk(active_fuses, 16'h91E1, "working copy held");
    rf(1'b1, 1'b0, 8'h11);
    @(posedge sys_clk) serial_mode <= 1'b1;
    op(8'h40, 8'hB1, 1'b1);
    rf(1'b1, 1'b0, 8'hB1);
    @(posedge sys_clk) serial_mode <= 1'b0;
    rf(1'b1, 1'b0, 8'h91);
    op(8'h40, 8'hE4, 1'b0);
    rf(1'b0, 1'b0, 8'hE4);
    op(8'h80, 8'h00, 1'b0);
    rf(1'b1, 1'b0, 8'h91);
    op(8'h20, 8'hFE, 1'b0);
    op(8'h40, 8'h00, 1'b0);
    rf(1'b0, 1'b0, 8'hE4);
    rf(1'b0, 1'b1, 8'hFE);
    m.leave();
    chk(active_fuses, 16'h91E4, "fuses after exit");
  endtask : t_fuses

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  // Main sequence: reset for ten cycles, then the scenarios in order.
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    serial_mode = 1'b0;
    errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    t_reset();
    t_entry();
    t_signature();
    t_pages();
    t_fuses();
    report_and_stop();
  end
endmodule : tb_parallel_program_fuse_interface
